// >>> mpbx_phy_model.sv
// External PHY model: captures transmit bytes or nibbles and echoes them back
`timescale 1ns/1ps
module mpbx_phy_model (
  // Clock
  input wire logic sys_clk,
  // MAC transmit
  input wire logic [7:0] gig_transmit_byte,
  input wire logic gig_tx_en,
  input wire logic gig_tx_err,
  input wire logic [3:0] nib_tx_data,
  input wire logic nib_tx_en,
  input wire logic nib_tx_err,
  // PHY receive
  output logic [7:0] gig_receive_byte,
  output logic gig_rx_dv,
  output logic gig_rx_err,
  output logic [3:0] nib_rx_data,
  output logic nib_rx_en,
  output logic nib_rx_err,
  // Captured transmit bytes or nibbles
  output logic [31:0] cap_word,
  output logic [3:0] cap_cnt
);
  initial begin
    gig_receive_byte = 8'hA5;
    gig_rx_dv = 1'b0;
    gig_rx_err = 1'b0;
    nib_rx_data = 4'h5;
    nib_rx_en = 1'b0;
    nib_rx_err = 1'b0;
    cap_word = 32'h0;
    cap_cnt = 4'h0;
  end
  always @(posedge sys_clk) begin
    if (gig_tx_en === 1'b1) begin
      cap_word <= {gig_transmit_byte, cap_word[31:8]};
      cap_cnt <= cap_cnt + 4'h1;
    end else if (nib_tx_en === 1'b1) begin
      cap_word <= {nib_tx_data, cap_word[31:4]};
      cap_cnt <= cap_cnt + 4'h1;
    end
    // Idle data toggles so a stale unit never looks valid
    gig_rx_dv <= gig_tx_en;
    gig_rx_err <= gig_tx_err;
    gig_receive_byte <= gig_tx_en ? gig_transmit_byte : ~gig_receive_byte;
    nib_rx_en <= nib_tx_en;
    nib_rx_err <= nib_tx_err;
    nib_rx_data <= nib_tx_en ? nib_tx_data : ~nib_rx_data;
  end
endmodule

// >>> mpbx_pkg.sv
// Constants for the MAC and 1000BASE-X PCS control block
package mpbx_pkg;
  localparam int ADDR_W = 8;
  // Word addresses on the register port
  localparam logic [7:0] OFS_MAC_CMD = 8'h02;
  localparam logic [7:0] OFS_STATUS = 8'h03;
  localparam logic [7:0] OFS_PCS_CTRL = 8'h10;
  localparam logic [7:0] OFS_TIMER_LO = 8'h12;
  localparam logic [7:0] OFS_TIMER_HI = 8'h13;
  localparam logic [7:0] OFS_IF_MODE = 8'h14;
  // Command register fields
  localparam int CMD_TX_ENA = 0;
  localparam int CMD_RX_ENA = 1;
  localparam int CMD_ETH_SPEED = 3;
  localparam int CMD_HD_ENABLE = 10;
  localparam int CMD_SW_RESET = 13;
  localparam int CMD_ENA_10 = 25;
  localparam logic [31:0] CMD_RESET = 32'h0000_0000;
  // PCS control fields
  localparam int PCS_SPEED_LSB = 6;
  localparam int PCS_DUPLEX = 8;
  localparam int PCS_SPEED_MSB = 13;
  localparam int PCS_AN_ENA = 12;
  localparam int PCS_RESET = 15;
  localparam logic [15:0] PCS_CTRL_RESET = 16'h1140;
  localparam logic [15:0] PCS_RO_MASK = 16'h2140;
  // Interface mode fields
  localparam int IFM_SGMII_ENA = 0;
  localparam logic [5:0] IF_MODE_RESET = 6'h00;
  localparam logic [15:0] TIMER_RESET = 16'h0000;
  // Self-clearing reset durations in sys_clk cycles
  localparam logic [7:0] PCS_RST_CYC = 8'h10;
  localparam logic [7:0] MAC_RST_CYC = 8'h10;
endpackage

// >>> mpbx_sva.sv
// Port checker for the MAC and PCS control block
`timescale 1ns/1ps
module mpbx_sva #(
  parameter int CLIENT_WORD_WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Mode and status
  input wire logic eth_mode,
  input wire logic half_duplex_enable,
  input wire logic pcs_sgmii_mode,
  input wire logic pcs_an_enable,
  input wire logic [31:0] autoneg_link_timer,
  // Datapath
  input wire logic client_tx_ready,
  input wire logic gig_tx_en,
  input wire logic [7:0] gig_receive_byte,
  input wire logic gig_rx_dv,
  input wire logic [7:0] rx_byte,
  input wire logic rx_byte_valid
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence s_take_done;
    $fell(client_tx_ready) && eth_mode && CLIENT_WORD_WIDTH == 32;
  endsequence
  sequence s_four_bytes;
    gig_tx_en [*4];
  endsequence
  // Mode outputs trail the register by one more flop stage
  chk_mode_write: assert property (
    reg_wr && reg_addr == mpbx_pkg::OFS_IF_MODE
    |-> ##2 pcs_sgmii_mode == $past(reg_wdata[0], 2))
    else $error("interface mode output does not follow write");
  chk_an_write: assert property (
    reg_wr && reg_addr == mpbx_pkg::OFS_PCS_CTRL
    |-> ##2 pcs_an_enable == $past(reg_wdata[12], 2))
    else $error("autonegotiation enable does not follow write");
  chk_duplex_write: assert property (
    reg_wr && reg_addr == mpbx_pkg::OFS_MAC_CMD
    |-> ##2 half_duplex_enable == $past(reg_wdata[10], 2))
    else $error("half duplex output does not follow write");
  chk_timer_low: assert property (
    reg_wr && reg_addr == mpbx_pkg::OFS_TIMER_LO
    |-> ##2 autoneg_link_timer[15:0] == $past(reg_wdata[15:0], 2))
    else $error("link timer low half does not follow write");
  chk_speed_bit: assert property (
    reg_wr && reg_addr == mpbx_pkg::OFS_MAC_CMD && reg_wdata[3] |-> ##[1:3] eth_mode)
    else $error("gigabit mode not raised by speed bit");
  chk_ro_bits: assert property (
    reg_rd && reg_addr == mpbx_pkg::OFS_PCS_CTRL && !pcs_sgmii_mode
    |=> (reg_rdata[15:0] & mpbx_pkg::PCS_RO_MASK) == 16'h0140)
    else $error("read-only control bits changed");
  chk_reset_clear: assert property (disable iff (1'b0)
    !rst_b ##1 !rst_b |-> reg_rdata == 32'h0 && !half_duplex_enable && !pcs_sgmii_mode
    && autoneg_link_timer == 32'h0 && !gig_tx_en && !rx_byte_valid)
    else $error("outputs not cleared in reset");
  chk_tx_bytes: assert property (
    s_take_done |=> s_four_bytes)
    else $error("transmit word not sent as four bytes");
  chk_rx_byte: assert property (
    rx_byte_valid && eth_mode |-> $past(gig_rx_dv) && rx_byte == $past(gig_receive_byte))
    else $error("received byte differs from sampled input");
endmodule
bind mpbx_top mpbx_sva #(.CLIENT_WORD_WIDTH(CLIENT_WORD_WIDTH)) mpbx_sva_inst (.*);

// >>> mpbx_top.sv
// MAC command and PCS control registers with PHY-side datapath
`timescale 1ns/1ps
module mpbx_top #(
  parameter int CLIENT_WORD_WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Register port
  input wire logic [mpbx_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Speed straps from the PHY
  input wire logic set_1000,
  input wire logic set_10,
  // Mode and status
  output logic eth_mode,
  output logic ena_10,
  output logic half_duplex_enable,
  output logic pcs_sgmii_mode,
  output logic pcs_an_enable,
  output logic [31:0] autoneg_link_timer,
  // Client transmit word
  input wire logic [CLIENT_WORD_WIDTH-1:0] client_tx_word,
  input wire logic client_tx_valid,
  input wire logic client_tx_err,
  output logic client_tx_ready,
  // PHY transmit
  output logic [7:0] gig_transmit_byte,
  output logic gig_tx_en,
  output logic gig_tx_err,
  output logic [3:0] nib_tx_data,
  output logic nib_tx_en,
  output logic nib_tx_err,
  // PHY receive
  input wire logic [7:0] gig_receive_byte,
  input wire logic gig_rx_dv,
  input wire logic gig_rx_err,
  input wire logic [3:0] nib_rx_data,
  input wire logic nib_rx_en,
  input wire logic nib_rx_err,
  // Received bytes toward the client
  output logic [7:0] rx_byte,
  output logic rx_byte_valid,
  output logic rx_byte_err
);
  // Shared countdown for both self-clearing resets
  function automatic logic [7:0] rst_step(input logic start, input logic [7:0] cnt,
                                           input logic [7:0] len);
    if (start) begin
      rst_step = len;
    end else if (cnt != 8'h00) begin
      rst_step = cnt - 8'h01;
    end else begin
      rst_step = 8'h00;
    end
  endfunction

  logic [31:0] cmd_q, cmd_d;
  logic [15:0] pcs_q, pcs_d;
  logic [5:0] ifm_q, ifm_d;
  logic [15:0] tlo_q, tlo_d, thi_q, thi_d;
  logic [7:0] pcnt_q, pcnt_d, mcnt_q, mcnt_d;
  logic [31:0] rd_q, rd_d;
  logic ethm_q, ethm_d, e10_q, e10_d, hd_q, hd_d;
  logic sg_q, sg_d, an_q, an_d;
  logic [31:0] lt_q, lt_d;
  logic [7:0] rxb_q, rxb_d;
  logic rxv_q, rxv_d, rxe_q, rxe_d;
  logic [3:0] lonib_q, lonib_d;
  logic half_q, half_d, nerr_q, nerr_d;
  logic wr_cmd, wr_pcs, pcs_start, mac_start, tx_on, rx_on;

  assign wr_cmd = reg_wr && reg_addr == mpbx_pkg::OFS_MAC_CMD;
  assign wr_pcs = reg_wr && reg_addr == mpbx_pkg::OFS_PCS_CTRL;
  assign pcs_start = wr_pcs && reg_wdata[mpbx_pkg::PCS_RESET];
  assign mac_start = wr_cmd && reg_wdata[mpbx_pkg::CMD_SW_RESET];
  // Datapaths sit idle while either reset sequence runs
  assign tx_on = cmd_q[mpbx_pkg::CMD_TX_ENA] && mcnt_q == 8'h00 && pcnt_q == 8'h00;
  assign rx_on = cmd_q[mpbx_pkg::CMD_RX_ENA] && mcnt_q == 8'h00 && pcnt_q == 8'h00;

  // Register file
  always_comb begin
    cmd_d = cmd_q;
    pcs_d = pcs_q;
    ifm_d = ifm_q;
    tlo_d = tlo_q;
    thi_d = thi_q;
    rd_d = 32'h0000_0000;
    pcnt_d = rst_step(pcs_start, pcnt_q, mpbx_pkg::PCS_RST_CYC);
    mcnt_d = rst_step(mac_start, mcnt_q, mpbx_pkg::MAC_RST_CYC);
    // Hardware finishing a reset clears the bit; a new write sets it again
    if (pcnt_q == 8'h01) begin
      pcs_d[mpbx_pkg::PCS_RESET] = 1'b0;
    end
    if (mcnt_q == 8'h01) begin
      cmd_d[mpbx_pkg::CMD_SW_RESET] = 1'b0;
    end
    if (reg_wr) begin
      unique case (reg_addr)
        mpbx_pkg::OFS_MAC_CMD: cmd_d = reg_wdata;
        mpbx_pkg::OFS_PCS_CTRL: begin
          if (!ifm_q[mpbx_pkg::IFM_SGMII_ENA]) begin
            pcs_d = (reg_wdata[15:0] & ~mpbx_pkg::PCS_RO_MASK) |
                    (pcs_q & mpbx_pkg::PCS_RO_MASK);
          end else begin
            pcs_d = reg_wdata[15:0];
          end
        end
        mpbx_pkg::OFS_TIMER_LO: tlo_d = reg_wdata[15:0];
        mpbx_pkg::OFS_TIMER_HI: thi_d = reg_wdata[15:0];
        mpbx_pkg::OFS_IF_MODE: ifm_d = reg_wdata[5:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        mpbx_pkg::OFS_MAC_CMD: rd_d = cmd_q;
        mpbx_pkg::OFS_STATUS: rd_d = {26'h0, rx_on, tx_on, e10_q, ethm_q,
                                      mcnt_q != 8'h00, pcnt_q != 8'h00};
        mpbx_pkg::OFS_PCS_CTRL: rd_d = {16'h0000, pcs_q};
        mpbx_pkg::OFS_TIMER_LO: rd_d = {16'h0000, tlo_q};
        mpbx_pkg::OFS_TIMER_HI: rd_d = {16'h0000, thi_q};
        mpbx_pkg::OFS_IF_MODE: rd_d = {26'h0, ifm_q};
        default: rd_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cmd_q <= mpbx_pkg::CMD_RESET;
      pcs_q <= mpbx_pkg::PCS_CTRL_RESET;
      ifm_q <= mpbx_pkg::IF_MODE_RESET;
      tlo_q <= mpbx_pkg::TIMER_RESET;
      thi_q <= mpbx_pkg::TIMER_RESET;
      pcnt_q <= 8'h00;
      mcnt_q <= 8'h00;
      rd_q <= 32'h0000_0000;
    end else begin
      cmd_q <= cmd_d;
      pcs_q <= pcs_d;
      ifm_q <= ifm_d;
      tlo_q <= tlo_d;
      thi_q <= thi_d;
      pcnt_q <= pcnt_d;
      mcnt_q <= mcnt_d;
      rd_q <= rd_d;
    end
  end

  // Mode outputs; straps only count when software leaves the bits clear
  always_comb begin
    ethm_d = cmd_q[mpbx_pkg::CMD_ETH_SPEED] | set_1000;
    e10_d = !ethm_d && (cmd_q[mpbx_pkg::CMD_ENA_10] | set_10);
    hd_d = cmd_q[mpbx_pkg::CMD_HD_ENABLE];
    sg_d = ifm_q[mpbx_pkg::IFM_SGMII_ENA];
    an_d = pcs_q[mpbx_pkg::PCS_AN_ENA];
    lt_d = {thi_q, tlo_q};
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ethm_q <= 1'b0;
      e10_q <= 1'b0;
      hd_q <= 1'b0;
      sg_q <= 1'b0;
      an_q <= 1'b0;
      lt_q <= 32'h0000_0000;
    end else begin
      ethm_q <= ethm_d;
      e10_q <= e10_d;
      hd_q <= hd_d;
      sg_q <= sg_d;
      an_q <= an_d;
      lt_q <= lt_d;
    end
  end

  // Receive: bytes at gigabit, nibble pairs low first otherwise
  always_comb begin
    rxb_d = 8'h00;
    rxv_d = 1'b0;
    rxe_d = 1'b0;
    lonib_d = lonib_q;
    half_d = 1'b0;
    nerr_d = 1'b0;
    if (rx_on) begin
      if (ethm_q) begin
        rxb_d = gig_receive_byte;
        rxv_d = gig_rx_dv;
        rxe_d = gig_rx_dv && gig_rx_err;
      end else if (nib_rx_en) begin
        // A lone trailing nibble is dropped when enable falls
        if (!half_q) begin
          lonib_d = nib_rx_data;
          half_d = 1'b1;
          nerr_d = nib_rx_err;
        end else begin
          rxb_d = {nib_rx_data, lonib_q};
          rxv_d = 1'b1;
          rxe_d = nerr_q | nib_rx_err;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rxb_q <= 8'h00;
      rxv_q <= 1'b0;
      rxe_q <= 1'b0;
      lonib_q <= 4'h0;
      half_q <= 1'b0;
      nerr_q <= 1'b0;
    end else begin
      rxb_q <= rxb_d;
      rxv_q <= rxv_d;
      rxe_q <= rxe_d;
      lonib_q <= lonib_d;
      half_q <= half_d;
      nerr_q <= nerr_d;
    end
  end

  mpbx_tx_serializer #(
    .WIDTH(CLIENT_WORD_WIDTH)
  ) u_tx (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .gig_mode(ethm_q),
    .path_on(tx_on),
    .word(client_tx_word),
    .word_valid(client_tx_valid),
    .word_err(client_tx_err),
    .word_ready(client_tx_ready),
    .gig_transmit_byte(gig_transmit_byte),
    .gig_tx_en(gig_tx_en),
    .gig_tx_err(gig_tx_err),
    .nib_tx_data(nib_tx_data),
    .nib_tx_en(nib_tx_en),
    .nib_tx_err(nib_tx_err)
  );

  assign reg_rdata = rd_q;
  assign eth_mode = ethm_q;
  assign ena_10 = e10_q;
  assign half_duplex_enable = hd_q;
  assign pcs_sgmii_mode = sg_q;
  assign pcs_an_enable = an_q;
  assign autoneg_link_timer = lt_q;
  assign rx_byte = rxb_q;
  assign rx_byte_valid = rxv_q;
  assign rx_byte_err = rxe_q;
endmodule

// >>> mpbx_tx_serializer.sv
// Splits client words into GMII bytes or MII nibbles
`timescale 1ns/1ps
module mpbx_tx_serializer #(
  parameter int WIDTH = 32
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Control
  input wire logic gig_mode,
  input wire logic path_on,
  // Client word
  input wire logic [WIDTH-1:0] word,
  input wire logic word_valid,
  input wire logic word_err,
  output logic word_ready,
  // PHY transmit
  output logic [7:0] gig_transmit_byte,
  output logic gig_tx_en,
  output logic gig_tx_err,
  output logic [3:0] nib_tx_data,
  output logic nib_tx_en,
  output logic nib_tx_err
);
  typedef enum logic [0:0] {
    SER_IDLE = 1'b0,
    SER_SEND = 1'b1
  } mpbx_ser_t;

  localparam logic [3:0] GIG_UNITS = 4'(WIDTH / 8);
  localparam logic [3:0] MII_UNITS = 4'(WIDTH / 4);

  // Refused at elaboration so a bad width never reaches the datapath
  if (WIDTH != 8 && WIDTH != 32) begin : g_width_check
    $error("client word width must be 8 or 32");
  end

  mpbx_ser_t st_q, st_d;
  logic [WIDTH-1:0] sh_q, sh_d;
  logic [3:0] cnt_q, cnt_d;
  logic err_q, err_d;
  logic rdy_q, rdy_d;
  logic [7:0] gb_q, gb_d;
  logic gen_q, gen_d, gerr_q, gerr_d;
  logic [3:0] nb_q, nb_d;
  logic nen_q, nen_d, nerr_q, nerr_d;

  always_comb begin
    st_d = st_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    err_d = err_q;
    rdy_d = 1'b0;
    gb_d = 8'h00;
    gen_d = 1'b0;
    gerr_d = 1'b0;
    nb_d = 4'h0;
    nen_d = 1'b0;
    nerr_d = 1'b0;
    unique case (st_q)
      SER_IDLE: begin
        rdy_d = path_on;
        if (word_valid && rdy_q && path_on) begin
          sh_d = word;
          err_d = word_err;
          cnt_d = gig_mode ? GIG_UNITS : MII_UNITS;
          st_d = SER_SEND;
          rdy_d = 1'b0;
        end
      end
      SER_SEND: begin
        // Disabling the path abandons the word rather than stalling forever
        if (!path_on) begin
          st_d = SER_IDLE;
        end else begin
          if (gig_mode) begin
            gb_d = sh_q[7:0];
            gen_d = 1'b1;
            gerr_d = err_q;
            sh_d = sh_q >> 8;
          end else begin
            nb_d = sh_q[3:0];
            nen_d = 1'b1;
            nerr_d = err_q;
            sh_d = sh_q >> 4;
          end
          cnt_d = cnt_q - 4'h1;
          if (cnt_q == 4'h1) begin
            st_d = SER_IDLE;
            rdy_d = 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= SER_IDLE;
      sh_q <= '0;
      cnt_q <= 4'h0;
      err_q <= 1'b0;
      rdy_q <= 1'b0;
      gb_q <= 8'h00;
      gen_q <= 1'b0;
      gerr_q <= 1'b0;
      nb_q <= 4'h0;
      nen_q <= 1'b0;
      nerr_q <= 1'b0;
    end else begin
      st_q <= st_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      err_q <= err_d;
      rdy_q <= rdy_d;
      gb_q <= gb_d;
      gen_q <= gen_d;
      gerr_q <= gerr_d;
      nb_q <= nb_d;
      nen_q <= nen_d;
      nerr_q <= nerr_d;
    end
  end

  assign word_ready = rdy_q;
  assign gig_transmit_byte = gb_q;
  assign gig_tx_en = gen_q;
  assign gig_tx_err = gerr_q;
  assign nib_tx_data = nb_q;
  assign nib_tx_en = nen_q;
  assign nib_tx_err = nerr_q;
endmodule

// >>> tb_top.sv
// Self-checking testbench for the MAC and PCS control block
`timescale 1ns/1ps
module tb_top;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata, autoneg_link_timer, word, cap_word, rx_word;
  logic set_1000 = 1'b0;
  logic set_10 = 1'b0;
  logic eth_mode, ena_10, half_duplex_enable, pcs_sgmii_mode, pcs_an_enable;
  logic [31:0] client_tx_word = 32'h0;
  logic client_tx_valid = 1'b0;
  logic client_tx_err = 1'b0;
  logic client_tx_ready, gig_tx_en, gig_tx_err, nib_tx_en, nib_tx_err, gig_rx_dv, gig_rx_err;
  logic nib_rx_en, nib_rx_err, rx_byte_valid, rx_byte_err;
  logic [7:0] gig_transmit_byte, gig_receive_byte, rx_byte;
  logic [3:0] nib_tx_data, nib_rx_data, cap_cnt;
  int num_errors = 0;
  int tests_run = 0;
  int rx_err_cnt = 0;
  always #2.5 sys_clk = ~sys_clk;
  mpbx_top #(.CLIENT_WORD_WIDTH(32)) mpbx_top_inst (.*);
  mpbx_phy_model mpbx_phy_model_inst (.*);
  always @(posedge sys_clk) begin
    if (rx_byte_valid === 1'b1) begin
      rx_word <= {rx_byte, rx_word[31:8]};
      rx_err_cnt <= rx_err_cnt + (rx_byte_err === 1'b1 ? 1 : 0);
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Poll until a self-clearing bit drops, bounded
  task automatic poll(input logic [7:0] a, input int b);
    int n;
    n = 0;
    do begin
      rd(a, word);
      n++;
    end while (word[b] !== 1'b0 && n < 40);
    chk(word[b], 1'b0);
  endtask
  task automatic t_reset;
    rd(mpbx_pkg::OFS_PCS_CTRL, word); chk(word, 32'h1140);
    rd(mpbx_pkg::OFS_IF_MODE, word); chk(word, 32'h0);
    rd(mpbx_pkg::OFS_MAC_CMD, word); chk(word, 32'h0);
    rd(mpbx_pkg::OFS_TIMER_LO, word); chk(word, 32'h0);
    rd(8'hFF, word); chk(word, 32'h0);
  endtask
  task automatic t_pcs;
    wr(mpbx_pkg::OFS_TIMER_LO, 32'h12D0);
    wr(mpbx_pkg::OFS_TIMER_HI, 32'h13);
    // Mode outputs settle one edge after the write lands, inside the two-edge wait
    repeat (2) @(posedge sys_clk);
    chk(autoneg_link_timer, 32'h0013_12D0);
    wr(mpbx_pkg::OFS_IF_MODE, 32'h1);
    repeat (2) @(posedge sys_clk);
    chk(pcs_sgmii_mode, 1'b1);
    wr(mpbx_pkg::OFS_IF_MODE, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk(pcs_sgmii_mode, 1'b0);
    wr(mpbx_pkg::OFS_PCS_CTRL, 32'h20BF);
    rd(mpbx_pkg::OFS_PCS_CTRL, word); chk(word & 32'h2140, 32'h0140);
    wr(mpbx_pkg::OFS_PCS_CTRL, 32'h1140);
    repeat (2) @(posedge sys_clk);
    chk(pcs_an_enable, 1'b1);
    wr(mpbx_pkg::OFS_PCS_CTRL, 32'h9140);
    rd(mpbx_pkg::OFS_PCS_CTRL, word); chk(word[15], 1'b1);
    poll(mpbx_pkg::OFS_PCS_CTRL, 15);
  endtask
  task automatic t_mac;
    logic [31:0] cmd [5] = '{32'h0, 32'h0, 32'h0200_0000, 32'h8, 32'h0};
    logic [1:0] strap [5] = '{2'b10, 2'b01, 2'b00, 2'b01, 2'b00};
    logic [1:0] exp [5] = '{2'b10, 2'b01, 2'b01, 2'b10, 2'b00};
    wr(mpbx_pkg::OFS_MAC_CMD, 32'h0);
    rd(mpbx_pkg::OFS_MAC_CMD, word); chk(word[1:0], 2'b00);
    wr(mpbx_pkg::OFS_MAC_CMD, 32'h2400);
    repeat (2) @(posedge sys_clk);
    chk(half_duplex_enable, 1'b1);
    poll(mpbx_pkg::OFS_MAC_CMD, 13);
    for (int i = 0; i < 5; i++) begin
      set_1000 <= strap[i][1];
      set_10 <= strap[i][0];
      wr(mpbx_pkg::OFS_MAC_CMD, cmd[i]);
      repeat (3) @(posedge sys_clk);
      chk({eth_mode, ena_10}, exp[i]);
    end
  endtask
  task automatic t_data;
    int n;
    int e0;
    set_1000 <= 1'b1;
    wr(mpbx_pkg::OFS_MAC_CMD, 32'h3);
    repeat (3) @(posedge sys_clk);
    e0 = rx_err_cnt;
    client_tx_word <= 32'h8C4D_2E17;
    client_tx_valid <= 1'b1;
    n = 0;
    do @(posedge sys_clk); while (client_tx_ready !== 1'b1 && ++n < 30);
    client_tx_valid <= 1'b0;
    chk(n < 30, 1'b1);
    n = 0;
    while (cap_cnt !== 4'h4 && n < 30) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 30, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk(cap_word, 32'h8C4D_2E17);
    chk(rx_word, 32'h8C4D_2E17);
    chk(rx_err_cnt - e0, 32'h0);
  endtask
  task automatic t_mii;
    int n;
    int e0;
    logic [3:0] c_end;
    // Strap alone moves to nibbles; the command already has the speed bit clear
    set_1000 <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(eth_mode, 1'b0);
    e0 = rx_err_cnt;
    c_end = cap_cnt + 4'h8;
    client_tx_word <= 32'h6B39_F1A4;
    client_tx_err <= 1'b1;
    client_tx_valid <= 1'b1;
    n = 0;
    do @(posedge sys_clk); while (client_tx_ready !== 1'b1 && ++n < 30);
    client_tx_valid <= 1'b0;
    client_tx_err <= 1'b0;
    chk(n < 30, 1'b1);
    n = 0;
    while (cap_cnt !== c_end && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    chk(n < 40, 1'b1);
    repeat (3) @(posedge sys_clk);
    chk(cap_word, 32'h6B39_F1A4);
    chk(rx_word, 32'h6B39_F1A4);
    chk(rx_err_cnt - e0, 32'h4);
  endtask
  task automatic t_midreset;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset;
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    t_reset;
    t_pcs;
    t_mac;
    t_data;
    t_mii;
    t_midreset;
    conclude;
  end
endmodule
